//--- design/comparator_map.vh
// Purpose: Register offsets, field positions and reset values of the comparator control
// Assumes: Included by the comparator control module only
// Notes: Offsets are byte addresses on the plain register port
`ifndef COMPARATOR_MAP_VH
`define COMPARATOR_MAP_VH

`define CMP_CSR_OFFSET 8'h30
`define CMP_CSR_DATA_ADDR 8'h50
`define CMP_CONV_B_OFFSET 8'h31
`define CMP_CONV_A_OFFSET 8'h32
`define CMP_CHAN_SEL_OFFSET 8'h33

`define CMP_BIT_POWER_OFF 7
`define CMP_BIT_BANDGAP 6
`define CMP_BIT_RESULT 5
`define CMP_BIT_FLAG 4
`define CMP_BIT_IRQ_EN 3
`define CMP_BIT_CAPTURE 2
`define CMP_BIT_MODE_HI 1
`define CMP_BIT_MODE_LO 0
`define CMP_BIT_MUX_EN 6
`define CMP_BIT_CONV_ON 7
`define CMP_CHAN_LSB 0
`define CMP_CHAN_MSB 2

`define CMP_MODE_TOGGLE 2'h0
`define CMP_MODE_RESERVED 2'h1
`define CMP_MODE_FALL 2'h2
`define CMP_MODE_RISE 2'h3

`define CMP_CSR_RESET 8'h00
`define CMP_CONV_B_RESET 8'h00
`define CMP_CONV_A_RESET 8'h00
`define CMP_CHAN_SEL_RESET 8'h00

`endif

//--- design/comparator_control.v
// Purpose: Digital control around an on-chip analog comparator
// Assumes: Analog comparator result arrives asynchronously; one 100 MHz clock
// Notes: Input selections are driven out to the analog macro from flip-flops
//
// Our own choice: the plain strobed port.
`include "comparator_map.vh"

// Summary of operation
// R1 - Result synchronised, one to two cycles latency
// R2 - Result high when positive exceeds negative
// R3 - Mux on, converter off: channel selects negative
// R4 - Otherwise negative pin feeds negative input
// R5 - Mux enable bit 6 of converter reg b
// R6 - Bandgap bit replaces positive pin input
// R7 - Power-off bit 7 may be set anytime
// R8 - Software disables irq before power change
// R9 - Flag bit 4 set on selected event
// R10 - Flag cleared when vector executes
// R11 - Writing one clears flag, zero keeps
// R12 - Request needs flag, enable, global enable
// R13 - Capture bit routes result to timer
// R14 - Capture bit clear disconnects timer route
// R15 - Software sets timer capture irq enable
// R16 - Software clears converter power reduction first
// R17 - Register at 0x30, mirror 0x50, reset zero
// R18 - Mode 00 toggle, 10 fall, 11 rise
// R19 - Software disables irq before mode change
// R20 - Edge compares result with previous cycle
module comparator_control
(
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Register port
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [7:0] rdata_o,
	// Analog comparator macro
	input wire cmp_raw_i,
	output wire power_off_o,
	output wire bandgap_positive_select_o,
	output wire use_channel_o,
	output wire [2:0] channel_select_o,
	// Converter enable from the converter block
	input wire converter_on_i,
	// CPU interrupt side
	input wire global_irq_enable_i,
	input wire vector_ack_i,
	output wire irq_o,
	// Timer capture front end
	output wire capture_in_o,
	output wire capture_sel_o
);

	reg sync1_ff;
	reg sync2_ff;
	reg prev_ff;
	reg power_off_ff;
	reg bandgap_ff;
	reg flag_ff;
	reg irq_en_ff;
	reg capture_ff;
	reg [1:0] mode_ff;
	reg [7:0] conv_b_ff;
	reg [7:0] conv_a_ff;
	reg [7:0] chan_sel_ff;
	reg [7:0] rdata_ff;
	reg irq_ff;
	reg use_channel_ff;
	reg [2:0] channel_ff;
	reg capture_in_ff;
	reg nxt_flag;
	reg event_hit;
	reg [7:0] nxt_rdata;
	wire csr_sel;
	wire conv_active;
	wire [7:0] csr_value;
	wire wr_csr;
	wire wr_conv_b;
	wire wr_conv_a;
	wire wr_chan;
	wire rd_csr;
	wire flag_clear;
	wire mux_route;

	// Two-stage synchroniser on the asynchronous result
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= cmp_raw_i; // R1 R2
			sync2_ff <= sync1_ff; // R1
			prev_ff <= sync2_ff; // R20
		end
	end

	assign csr_sel = (addr_i == `CMP_CSR_OFFSET) || (addr_i == `CMP_CSR_DATA_ADDR); // R17
	// Converter enable may come from the local copy or the converter itself
	assign conv_active = converter_on_i | conv_a_ff[`CMP_BIT_CONV_ON];

	// Write decodes, one per register; read decode for the CSR only
	assign wr_csr = wr_i & csr_sel;
	assign wr_conv_b = wr_i & (addr_i == `CMP_CONV_B_OFFSET);
	assign wr_conv_a = wr_i & (addr_i == `CMP_CONV_A_OFFSET);
	assign wr_chan = wr_i & (addr_i == `CMP_CHAN_SEL_OFFSET);
	assign rd_csr = rd_i & csr_sel;

	// Flag clears by a written one or by the vector
	assign flag_clear = vector_ack_i | (wr_csr & wdata_i[`CMP_BIT_FLAG]); // R10 R11

	// Channel feeds negative input only with converter off
	assign mux_route = conv_b_ff[`CMP_BIT_MUX_EN] & ~conv_active; // R3 R4 R5

	// Event detection per mode; reserved mode never fires
	always @*
	begin
		case (mode_ff) // R18
			`CMP_MODE_TOGGLE: event_hit = sync2_ff ^ prev_ff; // R20
			`CMP_MODE_FALL: event_hit = prev_ff & ~sync2_ff;
			`CMP_MODE_RISE: event_hit = ~prev_ff & sync2_ff;
			default: event_hit = 1'b0;
		endcase
	end

	// Set wins over any clear in the same cycle
	always @*
	begin
		nxt_flag = flag_ff;
		if (flag_clear)
		begin
			nxt_flag = 1'b0; // R10 R11
		end
		if (event_hit)
		begin
			nxt_flag = 1'b1; // R9
		end
	end

	assign csr_value = {power_off_ff, bandgap_ff, sync2_ff, flag_ff,
		irq_en_ff, capture_ff, mode_ff};

	// Read mux; idle and unmapped reads give zero
	always @*
	begin
		nxt_rdata = 8'h00;
		if (rd_csr)
		begin
			nxt_rdata = csr_value; // R1
		end
		else if (rd_i && addr_i == `CMP_CONV_B_OFFSET)
		begin
			nxt_rdata = conv_b_ff;
		end
		else if (rd_i && addr_i == `CMP_CONV_A_OFFSET)
		begin
			nxt_rdata = conv_a_ff;
		end
		else if (rd_i && addr_i == `CMP_CHAN_SEL_OFFSET)
		begin
			nxt_rdata = chan_sel_ff;
		end
	end

	// Interrupt flag
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			flag_ff <= 1'b0; // R17
		end
		else
		begin
			flag_ff <= nxt_flag;
		end
	end

	// Read data, one cycle after the strobe
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdata_ff <= 8'h00;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Writable control fields; result bit is read-only
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			power_off_ff <= 1'b0; // R17
			bandgap_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			capture_ff <= 1'b0;
			mode_ff <= 2'h0;
		end
		else if (wr_csr)
		begin
			power_off_ff <= wdata_i[`CMP_BIT_POWER_OFF]; // R7
			bandgap_ff <= wdata_i[`CMP_BIT_BANDGAP]; // R6
			irq_en_ff <= wdata_i[`CMP_BIT_IRQ_EN]; // R12
			capture_ff <= wdata_i[`CMP_BIT_CAPTURE]; // R13
			mode_ff <= {wdata_i[`CMP_BIT_MODE_HI], wdata_i[`CMP_BIT_MODE_LO]}; // R18
		end
	end

	// Converter register b, holds the mux enable
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			conv_b_ff <= `CMP_CONV_B_RESET;
		end
		else if (wr_conv_b)
		begin
			conv_b_ff <= wdata_i; // R5
		end
	end

	// Local copy of converter register a
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			conv_a_ff <= `CMP_CONV_A_RESET;
		end
		else if (wr_conv_a)
		begin
			conv_a_ff <= wdata_i;
		end
	end

	// Channel select register
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			chan_sel_ff <= `CMP_CHAN_SEL_RESET;
		end
		else if (wr_chan)
		begin
			chan_sel_ff <= wdata_i;
		end
	end

	// Interrupt request, same edge as the flag
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= nxt_flag & irq_en_ff & global_irq_enable_i; // R12
		end
	end

	// Negative input choice; channel holds while unused
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			use_channel_ff <= 1'b0;
			channel_ff <= 3'h0;
		end
		else
		begin
			use_channel_ff <= mux_route; // R3 R4 R5
			if (mux_route)
			begin
				channel_ff <= chan_sel_ff[`CMP_CHAN_MSB:`CMP_CHAN_LSB]; // R3
			end
		end
	end

	// Timer capture route, zero from one cycle after disconnection
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			capture_in_ff <= 1'b0;
		end
		else
		begin
			capture_in_ff <= capture_ff & sync2_ff; // R13 R14
		end
	end

	assign rdata_o = rdata_ff;
	assign power_off_o = power_off_ff;
	assign bandgap_positive_select_o = bandgap_ff;
	assign use_channel_o = use_channel_ff;
	assign channel_select_o = channel_ff;
	assign irq_o = irq_ff;
	assign capture_in_o = capture_in_ff;
	assign capture_sel_o = capture_ff;

endmodule // comparator_control

//--- bench/comparator_control_monitor.sv
// Purpose: Port checker
// Assumes: Bound into comparator_control
// Notes: Latencies as handed over
module comparator_control_monitor (
	input wire logic clk_i, rst_n_i, wr_i, cmp_raw_i, converter_on_i, global_irq_enable_i,
	input wire logic vector_ack_i, irq_o, power_off_o, bandgap_positive_select_o,
	input wire logic use_channel_o, capture_in_o, capture_sel_o,
	input wire logic [7:0] addr_i, wdata_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire wr_csr = wr_i && (addr_i == 8'h30 || addr_i == 8'h50);
	logic [2:0] mode_ff;
	always_ff @(posedge clk_i or negedge rst_n_i)
		if (!rst_n_i) mode_ff <= 3'h0;
		else if (wr_csr) mode_ff <= {wdata_i[3], wdata_i[1:0]};
	property p_fld; wr_csr |=> {power_off_o, bandgap_positive_select_o, capture_sel_o}
		== $past({wdata_i[7:6], wdata_i[2]}); endproperty
	a_fld: assert property (p_fld) else $error("field outputs");
	property p_cof; !capture_sel_o [*2] |-> !capture_in_o; endproperty
	a_cof: assert property (p_cof) else $error("capture leak");
	property p_con; (capture_sel_o && $stable(cmp_raw_i)) [*4] |-> capture_in_o == cmp_raw_i;
	endproperty
	a_con: assert property (p_con) else $error("capture path");
	property p_gie; irq_o |-> $past(global_irq_enable_i); endproperty
	a_gie: assert property (p_gie) else $error("irq gating");
	property p_mux; use_channel_o |-> !$past(converter_on_i); endproperty
	a_mux: assert property (p_mux) else $error("mux with converter on");
	property p_ack; $stable(cmp_raw_i) [*4] ##0 vector_ack_i |=> !irq_o; endproperty
	a_ack: assert property (p_ack) else $error("vector clear");
	property p_w1c; $stable(cmp_raw_i) [*4] ##0 (wr_csr && wdata_i[4]) |=> !irq_o; endproperty
	a_w1c: assert property (p_w1c) else $error("flag clear");
	property p_evt; mode_ff == 3'h7 && global_irq_enable_i && $rose(cmp_raw_i)
		##1 (!wr_i && !vector_ack_i && global_irq_enable_i) [*3] |-> ##[0:1] irq_o; endproperty
	a_evt: assert property (p_evt) else $error("rise event");
endmodule // comparator_control_monitor

//--- bench/analog_front.sv
// Purpose: Analog comparator macro model
// Assumes: Levels in millivolts
// Notes: Channel n sits at 100 mV times n
module analog_front #(parameter int NEG_MV = 500, parameter int BG_MV = 1100) (
	input wire logic power_off_o, bandgap_positive_select_o, use_channel_o,
	input wire logic [2:0] channel_select_o,
	input int pos,
	output logic cmp_raw_i
);
	always_comb
		cmp_raw_i = !power_off_o && (bandgap_positive_select_o ? BG_MV : pos) >
			(use_channel_o ? 100 * channel_select_o : NEG_MV);
endmodule // analog_front

//--- bench/comparator_control_tb.sv
// Purpose: Comparator control bench
// Assumes: analog_front stands in for the macro
// Notes: Pin levels in the capture test drawn from a shift register
module comparator_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, converter_on_i = 0;
	logic global_irq_enable_i = 0, vector_ack_i = 0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
	logic [31:0] seed = 32'h83effe6e;
	wire [7:0] rdata_o;
	wire cmp_raw_i, power_off_o, bandgap_positive_select_o, use_channel_o;
	wire irq_o, capture_in_o, capture_sel_o;
	wire [2:0] channel_select_o;
	int pos = 0, fails = 0, checked = 0;
	always #5 clk_i = ~clk_i;
	comparator_control DUT (.*);
	analog_front AF (.*);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] ev(input logic [1:0] m, input logic r);
		return {7'h0, m == 2'h0 || m == {1'b1, r}};
	endfunction
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Write when w, else read and expect d
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= w;
		rd_i <= !w;
		@(posedge clk_i);
		{wr_i, rd_i} <= 2'b00;
		#1 if (!w) cmp("rdata", d, rdata_o);
	endtask
	task automatic end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#50us;
		fails++;
		end_of_test;
	end
	initial
	begin
		tick(16);
		rst_n_i <= 1'b1;
		for (int a = 'h2f; a < 'h35; a++) bus(0, 8'(a), 8'h00);
		pos <= 900;
		bus(1, 8'h30, 8'h01);
		tick(3);
		bus(0, 8'h50, 8'h21);
		pos <= 350;
		bus(1, 8'h50, 8'h41);
		tick(3);
		bus(0, 8'h30, 8'h61);
		bus(1, 8'h30, 8'h01);
		bus(1, 8'h31, 8'h40);
		for (int i = 7; i >= 0; i--)
		begin
			bus(1, 8'h33, 8'(i));
			tick(3);
			bus(0, 8'h30, i < 4 ? 8'h21 : 8'h01);
		end
		for (int k = 0; k < 3; k++)
		begin
			converter_on_i <= k == 1;
			bus(1, 8'h32, k == 0 ? 8'h80 : 8'h00);
			tick(3);
			bus(0, 8'h30, k == 2 ? 8'h21 : 8'h01);
		end
		bus(1, 8'h31, 8'h00);
		pos <= 0;
		global_irq_enable_i <= 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			bus(1, 8'h30, 8'(m[2:1]));
			bus(1, 8'h30, 8'h18 | 8'(m[2:1]));
			pos <= m[0] ? 0 : 900;
			tick(6);
			cmp("irq", ev(m[2:1], !m[0]), {7'h0, irq_o});
			if (m[0])
				bus(1, 8'h30, 8'h18 | 8'(m[2:1]));
			else
			begin
				vector_ack_i <= 1'b1;
				tick(1);
				vector_ack_i <= 1'b0;
			end
			tick(2);
			cmp("irq cleared", 8'h00, {7'h0, irq_o});
		end
		bus(1, 8'h30, 8'h04);
		for (int j = 0; j < 20; j++)
		begin
			seed = lfsr(seed);
			pos <= seed[9:0];
			tick(5);
			cmp("capture", {7'h0, seed[9:0] > 500}, {7'h0, capture_in_o});
		end
		bus(1, 8'h30, 8'h11);
		pos <= 900;
		tick(5);
		cmp("capture off", 8'h00, {7'h0, capture_in_o});
		bus(1, 8'h30, 8'h81);
		tick(3);
		bus(0, 8'h30, 8'h81);
		end_of_test;
	end
endmodule // comparator_control_tb
bind comparator_control comparator_control_monitor MON (.*);
